// File: acs_seq_defs.svh
`ifndef ACS_SEQ_DEFS_SVH
`define ACS_SEQ_DEFS_SVH

// Register byte offsets on the Wishbone slave
`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_SHADOW 8'h04
`define ACS_OFS_STATUS 8'h08

// Control register fields
`define ACS_CTRL_ADDR_LSB 0
`define ACS_CTRL_ADDR_MSB 2
`define ACS_CTRL_SHADOW_ENABLE_BIT 3
`define ACS_CTRL_SEQ_BIT 4
`define ACS_CTRL_CFGLO_BIT 5
`define ACS_CTRL_CFGHI_BIT 6
`define ACS_CTRL_REF_BIT 7

// Status register fields
`define ACS_STAT_CHAN_LSB 0
`define ACS_STAT_RUN_BIT 3
`define ACS_STAT_MODE_LSB 4
`define ACS_STAT_REF_BIT 6

// Reset values
`define ACS_CTRL_RESET 8'h00
`define ACS_SHADOW_RESET 8'h00
`define ACS_CHAN_RESET 3'h0

`endif

// File: acs_pkg.sv
`default_nettype none

package acs_pkg;

  typedef enum logic [2:0]
  {
    ACS_DIRECT = 3'b001,
    ACS_PROG = 3'b010,
    ACS_CONSEC = 3'b100
  } acs_seq_state_t;

  // Encoded as {input_config_bit_high, input_config_bit_low}
  typedef enum logic [1:0]
  {
    ACS_SINGLE = 2'b00,
    ACS_PSEUDO_PAIRS = 2'b01,
    ACS_FULL_DIFF = 2'b10,
    ACS_PSEUDO_COMMON = 2'b11
  } acs_in_cfg_t;

endpackage : acs_pkg

`default_nettype wire

// File: acs_reg_if.sv
`timescale 1ns/1ns
`default_nettype none

interface acs_reg_if;
  logic ctrlWrite;
  logic shadowWrite;
  logic [7:0] ctrlWord;
  logic [7:0] shadowMask;
  logic [7:0] statusWord;

  modport regs
  (
    output ctrlWrite,
    output shadowWrite,
    output ctrlWord,
    output shadowMask,
    input statusWord
  );

  modport core
  (
    input ctrlWrite,
    input shadowWrite,
    input ctrlWord,
    input shadowMask,
    output statusWord
  );
endinterface : acs_reg_if

`default_nettype wire

// File: acs_wb_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_seq_defs.svh"

module acs_wb_regs
  import acs_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Toward the sequencer core
  acs_reg_if.regs rif
);

  logic take;
  logic wrLane0;

  // One request per ack; ack drops the cycle after it rose
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrLane0 = take & wb_we_i & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= take;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rif.ctrlWord <= `ACS_CTRL_RESET;
      rif.ctrlWrite <= 1'b0;
    end
    else if (ce)
    begin
      rif.ctrlWrite <= wrLane0 && wb_adr_i == `ACS_OFS_CTRL;
      if (wrLane0 && wb_adr_i == `ACS_OFS_CTRL)
        rif.ctrlWord <= wb_dat_i[7:0];
    end
  end

  // Whole mask lands in one write, no byte pairing
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rif.shadowMask <= `ACS_SHADOW_RESET;
      rif.shadowWrite <= 1'b0;
    end
    else if (ce)
    begin
      rif.shadowWrite <= wrLane0 && wb_adr_i == `ACS_OFS_SHADOW;
      if (wrLane0 && wb_adr_i == `ACS_OFS_SHADOW)
        rif.shadowMask <= wb_dat_i[7:0];
    end
  end

  // Unmapped addresses still ack, reading zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (ce && take && !wb_we_i)
    begin
      case (wb_adr_i)
        `ACS_OFS_CTRL: wb_dat_o <= {24'h000000, rif.ctrlWord};
        `ACS_OFS_SHADOW: wb_dat_o <= {24'h000000, rif.shadowMask};
        `ACS_OFS_STATUS: wb_dat_o <= {24'h000000, rif.statusWord};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule : acs_wb_regs

`default_nettype wire

// File: acs_chan_step.sv
`timescale 1ns/1ns
`default_nettype none

module acs_chan_step
  import acs_pkg::*;
#(
  parameter int NumChan = 8,
  parameter int ChanW = 3
)
(
  // Selection mask and current pointer
  input wire logic [NumChan-1:0] mask,
  input wire logic [ChanW-1:0] cur,
  // Results
  output logic [ChanW-1:0] lowest,
  output logic [ChanW-1:0] nextSel,
  output logic anySel
);

  logic foundNext;

  // Descending scan: the last hit is the smallest qualifying index
  always_comb
  begin
    lowest = '0;
    nextSel = '0;
    foundNext = 1'b0;
    for (int i = NumChan - 1; i >= 0; i--)
    begin
      if (mask[i])
        lowest = ChanW'(i);
      if (mask[i] && i > int'(cur))
      begin
        nextSel = ChanW'(i);
        foundNext = 1'b1;
      end
    end
    if (!foundNext)
      nextSel = lowest;
    anySel = |mask;
  end

endmodule : acs_chan_step

`default_nettype wire

// File: acs_channel_sequencer.sv
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "acs_seq_defs.svh"

module acs_channel_sequencer
  import acs_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter handshake
  input wire logic convDone,
  // Multiplexer and front-end control
  output logic [2:0] muxChannel,
  output acs_in_cfg_t inputMode,
  output logic diffPair,
  output logic commonNegIn,
  output logic refInternal,
  output logic seqActive
);

  acs_reg_if rif();

  acs_seq_state_t seqState_reg;
  logic [2:0] muxChannel_reg;
  logic [2:0] seqEnd_reg;
  acs_in_cfg_t inputMode_reg;
  logic diffPair_reg;
  logic commonNegIn_reg;
  logic refInternal_reg;
  logic seqActive_reg;
  logic seqActive_next;

  logic [2:0] addrField;
  logic [1:0] seqBits;
  logic ctrlLoad;
  logic [2:0] lowestSel;
  logic [2:0] nextSel;
  logic anySel;

  ////////////////////////////////////////////////////////////////////////
  acs_wb_regs u_regs
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif)
  );

  acs_chan_step #(.NumChan(8), .ChanW(3)) u_step
  (
    .mask(rif.shadowMask),
    .cur(muxChannel_reg),
    .lowest(lowestSel),
    .nextSel(nextSel),
    .anySel(anySel)
  );

  ////////////////////////////////////////////////////////////////////////
  assign addrField = rif.ctrlWord[`ACS_CTRL_ADDR_MSB:`ACS_CTRL_ADDR_LSB];
  assign seqBits = {rif.ctrlWord[`ACS_CTRL_SEQ_BIT],
                    rif.ctrlWord[`ACS_CTRL_SHADOW_ENABLE_BIT]};
  // The keep-running combination never reloads the pointer
  assign ctrlLoad = rif.ctrlWrite && seqBits != 2'b10;

  assign rif.statusWord = {1'b0, refInternal_reg, inputMode_reg,
                           seqActive_reg, muxChannel_reg};

  assign muxChannel = muxChannel_reg;
  assign inputMode = inputMode_reg;
  assign diffPair = diffPair_reg;
  assign commonNegIn = commonNegIn_reg;
  assign refInternal = refInternal_reg;
  assign seqActive = seqActive_reg;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seqState_reg <= ACS_DIRECT;
    else if (ce && rif.ctrlWrite)
    begin
      case (seqBits)
        2'b00: seqState_reg <= ACS_DIRECT;
        2'b01: seqState_reg <= ACS_PROG;
        2'b11: seqState_reg <= ACS_CONSEC;
        default: seqState_reg <= seqState_reg;
      endcase
    end
  end

  // Channel pointer; a load wins over an advance in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      muxChannel_reg <= `ACS_CHAN_RESET;
      seqEnd_reg <= `ACS_CHAN_RESET;
    end
    else if (ce)
    begin
      if (ctrlLoad)
      begin
        case (seqBits)
          2'b00: muxChannel_reg <= addrField;
          2'b01: muxChannel_reg <= lowestSel;
          default:
          begin
            muxChannel_reg <= 3'h0;
            seqEnd_reg <= addrField;
          end
        endcase
      end
      else if (rif.shadowWrite && seqState_reg == ACS_PROG)
        muxChannel_reg <= lowestSel;
      else if (convDone)
      begin
        // No register traffic needed to keep stepping
        case (seqState_reg)
          ACS_PROG:
            if (anySel)
              muxChannel_reg <= nextSel;
          ACS_CONSEC:
            if (muxChannel_reg == seqEnd_reg)
              muxChannel_reg <= 3'h0;
            else
              muxChannel_reg <= muxChannel_reg + 3'h1;
          default:
            muxChannel_reg <= muxChannel_reg;
        endcase
      end
    end
  end

  // Shadow mask plays no part in the consecutive run
  always_comb
  begin
    case (seqState_reg)
      ACS_PROG: seqActive_next = anySel;
      ACS_CONSEC: seqActive_next = 1'b1;
      default: seqActive_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seqActive_reg <= 1'b0;
    else if (ce)
      seqActive_reg <= seqActive_next;
  end

  // Input configuration and reference, applied on every control write
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inputMode_reg <= ACS_SINGLE;
      diffPair_reg <= 1'b0;
      commonNegIn_reg <= 1'b0;
      refInternal_reg <= 1'b0;
    end
    else if (ce && rif.ctrlWrite)
    begin
      refInternal_reg <= rif.ctrlWord[`ACS_CTRL_REF_BIT];
      case ({rif.ctrlWord[`ACS_CTRL_CFGHI_BIT],
             rif.ctrlWord[`ACS_CTRL_CFGLO_BIT]})
        2'b01:
        begin
          inputMode_reg <= ACS_PSEUDO_PAIRS;
          diffPair_reg <= 1'b1;
          commonNegIn_reg <= 1'b0;
        end
        2'b10:
        begin
          inputMode_reg <= ACS_FULL_DIFF;
          diffPair_reg <= 1'b1;
          commonNegIn_reg <= 1'b0;
        end
        2'b11:
        begin
          inputMode_reg <= ACS_PSEUDO_COMMON;
          diffPair_reg <= 1'b0;
          commonNegIn_reg <= 1'b1;
        end
        default:
        begin
          inputMode_reg <= ACS_SINGLE;
          diffPair_reg <= 1'b0;
          commonNegIn_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_direct_addr_load: assert property (
    ce && rif.ctrlWrite && seqBits == 2'b00
    |=> muxChannel == $past(addrField) && seqState_reg == ACS_DIRECT)
    else $error("direct write did not load addressed channel");

  a_prog_first_lowest: assert property (
    ce && rif.shadowWrite && !ctrlLoad && seqState_reg == ACS_PROG
    |=> muxChannel == $past(lowestSel))
    else $error("shadow load did not start at lowest channel");

  a_prog_only_selected: assert property (
    ce && convDone && !ctrlLoad && !rif.shadowWrite
    && seqState_reg == ACS_PROG && anySel
    |=> rif.shadowMask[muxChannel])
    else $error("sequence stepped to an unselected channel");

  a_prog_wrap_low: assert property (
    ce && convDone && !ctrlLoad && !rif.shadowWrite
    && seqState_reg == ACS_PROG && anySel && nextSel <= muxChannel
    |=> muxChannel == $past(lowestSel))
    else $error("sequence did not wrap to lowest channel");

  a_keep_on_hold: assert property (
    ce && rif.ctrlWrite && seqBits == 2'b10 && !convDone
    && !rif.shadowWrite
    |=> $stable(muxChannel) && $stable(seqState_reg))
    else $error("keep-running write disturbed the sequence");

  a_consec_restart: assert property (
    ce && rif.ctrlWrite && seqBits == 2'b11
    |=> muxChannel == 3'h0 && seqState_reg == ACS_CONSEC)
    else $error("consecutive start not at channel 0");

  a_consec_wrap: assert property (
    ce && convDone && !ctrlLoad && seqState_reg == ACS_CONSEC
    && muxChannel == seqEnd_reg
    |=> muxChannel == 3'h0)
    else $error("consecutive run did not restart at 0");

  a_consec_step_one: assert property (
    ce && convDone && !ctrlLoad && seqState_reg == ACS_CONSEC
    && muxChannel != seqEnd_reg
    |=> muxChannel == 3'($past(muxChannel) + 3'h1))
    else $error("consecutive pointer did not step by one");

  a_idle_no_step: assert property (
    ce && !convDone && !rif.ctrlWrite && !rif.shadowWrite
    |=> $stable(muxChannel))
    else $error("pointer moved without a conversion");

  a_consec_no_shadow: assert property (
    ce && rif.shadowWrite && !ctrlLoad && !convDone
    && seqState_reg == ACS_CONSEC
    |=> $stable(muxChannel) && seqActive_reg)
    else $error("shadow write disturbed consecutive run");

  a_ref_select: assert property (
    ce && rif.ctrlWrite
    |=> refInternal == $past(rif.ctrlWord[`ACS_CTRL_REF_BIT]))
    else $error("reference select not applied");

  a_cfg_decode: assert property (
    ce && rif.ctrlWrite
    && rif.ctrlWord[`ACS_CTRL_CFGHI_BIT:`ACS_CTRL_CFGLO_BIT] == 2'b11
    |=> commonNegIn && !diffPair && inputMode == ACS_PSEUDO_COMMON)
    else $error("seven-input pseudo mode decoded wrongly");

  c_prog_wrap: cover property (
    ce && convDone && seqState_reg == ACS_PROG && nextSel < muxChannel);

  c_consec_wrap: cover property (
    ce && convDone && seqState_reg == ACS_CONSEC
    && muxChannel == seqEnd_reg && seqEnd_reg != 3'h0);

  c_keep_write: cover property (
    ce && rif.ctrlWrite && seqBits == 2'b10 && seqActive_reg);

endmodule : acs_channel_sequencer

`default_nettype wire

// File: acs_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module acs_host_model
(
  // Clock
  input wire logic mclk,
  // Wishbone master
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datOut,
  input wire logic [31:0] datIn,
  input wire logic ack
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datOut = 32'h0;
  end

  // One whole byte per write, shadow mask included
  // Callers only write seq,shadow_enable = 1,0 while a run must go on
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    datOut <= {24'h0, d};
    // Waits as long as it takes; only the bench timeout ends a hang
    while (!ok)
    begin
      @(posedge mclk);
      if (ack === 1'b1)
      begin
        ok = 1'b1;
        q = datIn;
      end
    end
    // Released only at the edge that saw ack
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
endmodule : acs_host_model

`default_nettype wire

// File: tb_adc_channel_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module tb_adc_channel_sequencer
  import acs_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic convDone = 1'b0;
  logic cyc, stb, we, ack, diffPair, commonNegIn, refInternal, seqActive;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR, q;
  logic [2:0] muxChannel;
  acs_in_cfg_t inputMode;
  logic ok;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;
  int mMode, mMask, mPtr, mEnd, mCfg, mRef;

  always #20 mclk = ~mclk;

  acs_channel_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .convDone(convDone), .muxChannel(muxChannel), .inputMode(inputMode),
    .diffPair(diffPair), .commonNegIn(commonNegIn),
    .refInternal(refInternal), .seqActive(seqActive));

  acs_host_model host_u (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .datOut(datW), .datIn(datR), .ack(ack));

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      giveVerdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic int lowest(int m);
    for (int i = 0; i < 8; i++)
      if (m[i])
        return i;
    return 0;
  endfunction : lowest

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(w, a, d, q, ok);
    if (!ok)
      fails++;
  endtask : bus

  task automatic checkAll();
    int st;
    repeat (2) @(posedge mclk);
    st = (mRef << 6) | (mCfg << 4) | (mPtr & 7);
    if (mMode == 2 || (mMode == 1 && mMask != 0))
      st = st | 8;
    `CHK(muxChannel, mPtr[2:0])
    `CHK(inputMode, mCfg[1:0])
    `CHK(diffPair, mCfg == 1 || mCfg == 2)
    `CHK(commonNegIn, mCfg == 3)
    `CHK(refInternal, mRef[0])
    `CHK(seqActive, st[3])
    bus(1'b0, 8'h08, 8'h00);
    `CHK(q, st)
  endtask : checkAll

  task automatic ctrlWr(input logic [7:0] d);
    bus(1'b1, 8'h00, d);
    mCfg = d[6:5];
    mRef = d[7];
    // Seq,shadow_enable = 1,0 leaves program and pointer alone
    case (d[4:3])
      2'b00: begin mMode = 0; mPtr = d[2:0]; end
      2'b01: begin mMode = 1; mPtr = lowest(mMask); end
      2'b11: begin mMode = 2; mPtr = 0; mEnd = d[2:0]; end
      default: ;
    endcase
    checkAll();
  endtask : ctrlWr

  task automatic shWr(input logic [7:0] m);
    bus(1'b1, 8'h04, m);
    mMask = m;
    if (mMode == 1)
      mPtr = lowest(mMask);
    bus(1'b0, 8'h04, 8'h00);
    `CHK(q, {24'h0, m})
    checkAll();
  endtask : shWr

  // Frozen clock enable must swallow conversions
  task automatic freeze();
    @(posedge mclk);
    ce <= 1'b0;
    convDone <= 1'b1;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    convDone <= 1'b0;
    @(posedge mclk);
    `CHK(muxChannel, mPtr[2:0])
  endtask : freeze

  // Back-to-back pulses when n > 1
  task automatic conv(input int n);
    @(posedge mclk);
    convDone <= 1'b1;
    repeat (n) @(posedge mclk);
    convDone <= 1'b0;
    repeat (n)
    begin
      if (mMode == 2)
        mPtr = (mPtr == mEnd) ? 0 : mPtr + 1;
      else if (mMode == 1 && mMask != 0)
      begin
        for (int i = mPtr + 1; i <= 8; i++)
          if (i == 8 || mMask[i % 8])
          begin
            mPtr = (i == 8) ? lowest(mMask) : i;
            break;
          end
      end
    end
    @(posedge mclk);
    `CHK(muxChannel, mPtr[2:0])
  endtask : conv

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h5193));
    {mMode, mMask, mPtr, mEnd, mCfg, mRef} = '0;
    repeat (3) @(posedge mclk);
    `CHK({muxChannel, inputMode, seqActive, refInternal}, 7'h00)
    rst_n <= 1'b1;
    checkAll();
    // Unmapped place answers with zero
    bus(1'b0, 8'h0C, 8'h00);
    `CHK(q, 32'h0)
    for (int i = 0; i < 4; i++)
      ctrlWr({1'($urandom), 2'(i), 2'b00, 3'($urandom)});
    conv(2);
    for (int r = 0; r < 3; r++)
    begin
      shWr(8'($urandom_range(1, 255)));
      ctrlWr({3'($urandom), 2'b01, 3'($urandom)});
      for (int k = 0; k < 12; k++)
      begin
        conv($urandom_range(1, 3));
        if (k == 4)
          ctrlWr({3'($urandom), 2'b10, 3'($urandom)});
        if (k == 8)
          shWr(8'($urandom_range(1, 255)));
      end
    end
    ctrlWr(8'h05);
    conv(1);
    for (int r = 0; r < 3; r++)
    begin
      shWr(8'($urandom));
      ctrlWr({3'($urandom), 2'b11, (r == 0) ? 3'h0 : (r == 1) ? 3'h7
        : 3'($urandom)});
      for (int k = 0; k < 10; k++)
      begin
        conv($urandom_range(1, 3));
        if (k == 2)
          freeze();
        if (k == 5)
          ctrlWr({3'($urandom), 2'b10, 3'($urandom)});
      end
    end
    giveVerdict();
  end
endmodule : tb_adc_channel_sequencer

`default_nettype wire
